// File: lpsc_pkg.sv
// package: constants for the link power-state control block
package lpsc_pkg;
	// device capability word field positions
	localparam int L0S_ACC_LSB = 6;
	localparam int L0S_ACC_MSB = 8;
	localparam int L1_ACC_LSB  = 9;
	localparam int L1_ACC_MSB  = 11;
	// link capability word field positions
	localparam int ASPM_SUP_LSB = 10;
	localparam int ASPM_SUP_MSB = 11;
	localparam int L0S_EXIT_LSB = 12;
	localparam int L0S_EXIT_MSB = 14;
	localparam int L1_EXIT_LSB  = 15;
	localparam int L1_EXIT_MSB  = 17;
	// encodings
	localparam logic [1:0] PSTATE_D0  = 2'h0;
	localparam logic [1:0] SUP_NONE   = 2'h0;
	localparam logic [1:0] SUP_L0S    = 2'h1;
	localparam logic [1:0] SUP_L1     = 2'h2;
	localparam logic [2:0] LAT_ZERO   = 3'h0;
	// reset values
	localparam logic [1:0]  PSTATE_RST = 2'h0;
	localparam logic [15:0] CNT_RST    = 16'h0000;
	// cycles between repeated entry DLLP requests
	localparam int DLLP_GAP = 8;

	// power management sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_L0      = 7'h01,
		ST_L0S     = 7'h02,
		ST_BLOCK   = 7'h04,
		ST_DRAIN   = 7'h08,
		ST_HSHAKE  = 7'h10,
		ST_L1      = 7'h20,
		ST_EXIT    = 7'h40
	} lpsc_state_t;
endpackage : lpsc_pkg

// File: lpsc_l0s_if.sv
// interface: signals between the sequencer and the l0s timer
`timescale 1ns/1ps
`default_nettype none
interface lpsc_l0s_if;
	logic        tx_idle;    // transmit side idle
	logic        allow;      // l0s permitted now
	logic        exit_done;  // ltssm reports l0s exit complete
	logic [15:0] entry_time; // idle cycles before entry
	logic [15:0] exit_time;  // expected exit cycles
	logic [15:0] extension;  // extra wait before recovery
	logic        in_l0s;     // transmitter in l0s
	logic        exiting;    // exit in progress
	logic        recovery;   // direct ltssm to recovery
	modport seq (output tx_idle, allow, exit_done, entry_time, exit_time, extension,
		input in_l0s, exiting, recovery);
	modport tmr (input tx_idle, allow, exit_done, entry_time, exit_time, extension,
		output in_l0s, exiting, recovery);
endinterface : lpsc_l0s_if
`default_nettype wire

// File: lpsc_l0s_timer.sv
// module: transmit l0s entry and exit timing
`timescale 1ns/1ps
`default_nettype none
module lpsc_l0s_timer
(
	input  wire logic  clk,   // core clock
	input  wire logic  rst,   // async reset, active high
	lpsc_l0s_if.tmr    l0s    // sequencer side
);
	logic [15:0] idle_cnt;
	logic [15:0] exit_cnt;
	logic        in_l0s;
	logic        exiting;
	logic        recovery;

	// idle counter restarts on any transmit activity
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			idle_cnt <= lpsc_pkg::CNT_RST;
		else if (!l0s.tx_idle || !l0s.allow || in_l0s)
			idle_cnt <= lpsc_pkg::CNT_RST;
		else if (idle_cnt != 16'hffff)
			idle_cnt <= idle_cnt + 16'h0001;
	end

	// entry after configured idle time, leave on pending traffic
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			in_l0s <= 1'b0;
		else if (in_l0s && (!l0s.tx_idle || !l0s.allow))
			in_l0s <= 1'b0;
		else if (!in_l0s && !exiting && l0s.allow && l0s.tx_idle
			&& idle_cnt >= l0s.entry_time)
			in_l0s <= 1'b1;
	end

	// exit watchdog: expected time plus extension, then recovery
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			exiting  <= 1'b0;
			exit_cnt <= lpsc_pkg::CNT_RST;
			recovery <= 1'b0;
		end
		else
		begin
			recovery <= 1'b0;
			if (in_l0s && (!l0s.tx_idle || !l0s.allow))
			begin
				exiting  <= 1'b1;
				exit_cnt <= lpsc_pkg::CNT_RST;
			end
			else if (exiting)
			begin
				if (l0s.exit_done)
					exiting <= 1'b0;
				else if ({1'b0, exit_cnt} >= {1'b0, l0s.exit_time} + {1'b0, l0s.extension})
				begin
					exiting  <= 1'b0;
					recovery <= 1'b1;
				end
				else
					exit_cnt <= exit_cnt + 16'h0001;
			end
		end
	end

	assign l0s.in_l0s   = in_l0s;
	assign l0s.exiting  = exiting;
	assign l0s.recovery = recovery;
endmodule // lpsc_l0s_timer
`default_nettype wire

// File: lpsc_top.sv
// module: link power-state control, capability words and l1 sequencer
// Overview of operation
// - enter transmit l0s only after the configured idle time of tlp and dllp traffic
// - take fast-training-set count from configuration and advertise it
// - failed l0s exit waits expected time plus extension, then recovery
// - device caps bits 8:6 carry the l0s acceptable latency code
// - non-endpoints read zero in both acceptable latency fields
// - link caps bits 14:12 carry the l0s exit latency code
// - support field bits 11:10 shows l0s bit when l0s enabled
// - support field shows l1 bit when l1 enabled, 00 when neither is enabled
// - non-d0 power state write starts the l1 entry sequence
// - block new tlps, finish current, wait replay empty and acked
// - repeat enter-l1 dllps until ack, then direct ltssm to l1
// - return to l0 on partner exit of l1, or on pending tlp once the power state is d0
// - device caps bits 11:9 carry the l1 acceptable latency code
// - link caps bits 17:15 carry the l1 exit latency code
// - autonomous l1 only when acting as endpoint upstream port
// - autonomous l1 needs enabled, advertised, and software enabled
// - autonomous l1 requested when no tlps, acks or naks sent
// - with l0s enabled, enter when tx idle, leave when data waits
`timescale 1ns/1ps
`default_nettype none
module lpsc_top
(
	input  wire logic        REF_CLK,          // core clock, 40 mhz
	input  wire logic        RST,              // async reset, active high
	// static configuration
	input  wire logic        IS_ENDPOINT,      // core acts as upstream port
	input  wire logic        L0S_SUPPORT,      // l0s support enabled
	input  wire logic        L1_SUPPORT,       // aspm l1 support enabled
	input  wire logic [2:0]  L0S_ACC_LAT,      // l0s acceptable latency code
	input  wire logic [2:0]  L1_ACC_LAT,       // l1 acceptable latency code
	input  wire logic [2:0]  L0S_EXIT_LAT,     // l0s exit latency code
	input  wire logic [2:0]  L1_EXIT_LAT,      // l1 exit latency code
	input  wire logic [7:0]  NFTS_COUNT,       // fts sets needed by local receiver
	input  wire logic [15:0] L0S_IDLE_ENTRY_TIME,  // idle cycles before l0s
	input  wire logic [15:0] FTS_TIMEOUT_EXTENSION, // cycles beyond expected exit
	input  wire logic [15:0] L0S_EXIT_TIME,    // expected l0s exit cycles
	input  wire logic [15:0] L1_IDLE_TIME,     // idle cycles before aspm l1
	// software control
	input  wire logic        PSTATE_WR,        // power state write strobe
	input  wire logic [1:0]  PSTATE_WDATA,     // power state write data
	input  wire logic        L0S_SW_EN,        // link control l0s enable
	input  wire logic        L1_SW_EN,         // link control l1 enable
	// transmit and link status from the core
	input  wire logic        TLP_PENDING,      // tlp waiting to be sent
	input  wire logic        TLP_IN_PROGRESS,  // tlp on the wire now
	input  wire logic        DLLP_ACTIVE,      // dllp being sent
	input  wire logic        ACKNAK_ACTIVE,    // ack or nak dllp being sent
	input  wire logic        REPLAY_EMPTY,     // replay buffer empty, all acked
	input  wire logic        PM_ACK_RCVD,      // request-ack dllp received
	input  wire logic        LTSSM_L0S_EXITED, // ltssm finished l0s exit
	input  wire logic        LTSSM_L1_EXITED,  // ltssm left l1 on partner activity
	// outputs
	output logic [1:0]       PSTATE,           // power state field readback
	output logic [31:0]      DEV_CAP,          // device capability word
	output logic [31:0]      LINK_CAP,         // link capability word
	output logic [7:0]       NFTS_ADV,         // advertised fts count
	output logic             TLP_BLOCK,        // hold new tlp transmission
	output logic             SEND_ENTER_L1,    // pulse: send enter-l1 dllp
	output logic             LTSSM_TO_L1,      // direct ltssm into l1
	output logic             LTSSM_TO_L0,      // pulse: direct ltssm back to l0
	output logic             LTSSM_RECOVERY,   // pulse: direct ltssm to recovery
	output logic             TX_L0S,           // transmitter in l0s
	output logic             LINK_IN_L1        // sequencer state is l1
);
	// l0s timer carrier and sequencer state
	lpsc_l0s_if          l0s ();
	lpsc_pkg::lpsc_state_t state;
	lpsc_pkg::lpsc_state_t next_state;
	logic [1:0]          pstate;
	logic                sw_l1_req;
	logic                aspm_l1_ok;
	logic                link_idle;
	logic [15:0]         l1_idle_cnt;
	logic [3:0]          gap_cnt;
	logic                aspm_entry;

	// support code as one field of two bits
	function automatic logic [1:0] support_code(input logic l0s_en, input logic l1_en);
		support_code = (l0s_en ? lpsc_pkg::SUP_L0S : lpsc_pkg::SUP_NONE)
			| (l1_en ? lpsc_pkg::SUP_L1 : lpsc_pkg::SUP_NONE);
	endfunction

	// latency field zeroed unless endpoint
	function automatic logic [2:0] ep_lat(input logic ep, input logic [2:0] code);
		ep_lat = ep ? code : lpsc_pkg::LAT_ZERO;
	endfunction

	// power state field; the only software-writable bits here
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			pstate <= lpsc_pkg::PSTATE_RST;
		else if (PSTATE_WR)
			pstate <= PSTATE_WDATA;
	end

	// software request stays while the state is non-d0
	assign sw_l1_req = (pstate != lpsc_pkg::PSTATE_D0);

	// autonomous l1 gating: endpoint, advertised, software enabled
	assign aspm_l1_ok = IS_ENDPOINT && L1_SUPPORT && L1_SW_EN;
	assign link_idle  = !TLP_PENDING && !TLP_IN_PROGRESS && !ACKNAK_ACTIVE;

	// idle time count for autonomous l1
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			l1_idle_cnt <= lpsc_pkg::CNT_RST;
		else if (!link_idle || !aspm_l1_ok || state != lpsc_pkg::ST_L0 && state != lpsc_pkg::ST_L0S)
			l1_idle_cnt <= lpsc_pkg::CNT_RST;
		else if (l1_idle_cnt != 16'hffff)
			l1_idle_cnt <= l1_idle_cnt + 16'h0001;
	end
	assign aspm_entry = aspm_l1_ok && link_idle && (l1_idle_cnt >= L1_IDLE_TIME);

	// l0s timer hookup; l0s only in l0 and only when supported and enabled
	assign l0s.tx_idle    = !TLP_PENDING && !TLP_IN_PROGRESS && !DLLP_ACTIVE;
	assign l0s.allow      = L0S_SUPPORT && L0S_SW_EN
		&& (state == lpsc_pkg::ST_L0 || state == lpsc_pkg::ST_L0S);
	assign l0s.exit_done  = LTSSM_L0S_EXITED;
	assign l0s.entry_time = L0S_IDLE_ENTRY_TIME;
	assign l0s.exit_time  = L0S_EXIT_TIME;
	assign l0s.extension  = FTS_TIMEOUT_EXTENSION;

	lpsc_l0s_timer u_l0s
	(
		.clk (REF_CLK),
		.rst (RST),
		.l0s (l0s.tmr)
	);

	// sequencer next state; each l1 entry step waits on its own condition,
	// so a slow partner or a long replay drain only stretches that step
	always_comb
	begin
		next_state = state;
		unique case (state)
			lpsc_pkg::ST_L0:
				if (sw_l1_req || aspm_entry)
					next_state = lpsc_pkg::ST_BLOCK;
				else if (l0s.in_l0s)
					next_state = lpsc_pkg::ST_L0S;
			lpsc_pkg::ST_L0S:
				// leave on l0s exit or any l1 request; l1 entry always starts from l0
				if (!l0s.in_l0s || sw_l1_req || aspm_entry)
					next_state = lpsc_pkg::ST_L0;
			lpsc_pkg::ST_BLOCK:
				if (!TLP_IN_PROGRESS)
					next_state = lpsc_pkg::ST_DRAIN;
			lpsc_pkg::ST_DRAIN:
				if (REPLAY_EMPTY && !TLP_IN_PROGRESS)
					next_state = lpsc_pkg::ST_HSHAKE;
				else if (!sw_l1_req && TLP_PENDING)
					next_state = lpsc_pkg::ST_L0;
			lpsc_pkg::ST_HSHAKE:
				if (PM_ACK_RCVD)
					next_state = lpsc_pkg::ST_L1;
			lpsc_pkg::ST_L1:
				if (LTSSM_L1_EXITED || TLP_PENDING && !sw_l1_req)
					next_state = lpsc_pkg::ST_EXIT;
			lpsc_pkg::ST_EXIT:
				next_state = lpsc_pkg::ST_L0;
			default:
				next_state = lpsc_pkg::ST_L0;
		endcase
	end

	// sequencer state register
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			state <= lpsc_pkg::ST_L0;
		else
			state <= next_state;
	end

	// enter-l1 dllp repeat spacing; pulses every gap until ack
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			gap_cnt       <= 4'h0;
			SEND_ENTER_L1 <= 1'b0;
		end
		else if (state == lpsc_pkg::ST_HSHAKE && !PM_ACK_RCVD)
		begin
			SEND_ENTER_L1 <= (gap_cnt == 4'h0);
			gap_cnt       <= (gap_cnt == 4'(lpsc_pkg::DLLP_GAP - 1)) ? 4'h0 : gap_cnt + 4'h1;
		end
		else
		begin
			gap_cnt       <= 4'h0;
			SEND_ENTER_L1 <= 1'b0;
		end
	end

	// transmit hold from block through l1; taken from next_state so the hold
	// is already up in the cycle the sequencer arrives in the block step
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			TLP_BLOCK <= 1'b0;
		else
			TLP_BLOCK <= (next_state == lpsc_pkg::ST_BLOCK)
				|| (next_state == lpsc_pkg::ST_DRAIN)
				|| (next_state == lpsc_pkg::ST_HSHAKE)
				|| (next_state == lpsc_pkg::ST_L1);
	end

	// l1 command to the ltssm and the matching status level; both stand
	// for as long as the sequencer sits in l1
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			LTSSM_TO_L1 <= 1'b0;
			LINK_IN_L1  <= 1'b0;
		end
		else
		begin
			LTSSM_TO_L1 <= (next_state == lpsc_pkg::ST_L1);
			LINK_IN_L1  <= (next_state == lpsc_pkg::ST_L1);
		end
	end

	// wake command; the exit step lasts one cycle, so this is a pulse
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			LTSSM_TO_L0 <= 1'b0;
		else
			LTSSM_TO_L0 <= (next_state == lpsc_pkg::ST_EXIT);
	end

	// l0s status and recovery request, retimed so every ltssm command
	// leaves a flop; costs one cycle of latency on both
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			LTSSM_RECOVERY <= 1'b0;
			TX_L0S         <= 1'b0;
		end
		else
		begin
			LTSSM_RECOVERY <= l0s.recovery;
			TX_L0S         <= l0s.in_l0s;
		end
	end

	// device capability word: latency codes only, every other bit zero;
	// built from static inputs, so no software write can reach it
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			DEV_CAP <= 32'h0000_0000;
		else
		begin
			DEV_CAP <= 32'h0000_0000;
			DEV_CAP[lpsc_pkg::L0S_ACC_MSB:lpsc_pkg::L0S_ACC_LSB]
				<= ep_lat(IS_ENDPOINT, L0S_ACC_LAT);
			DEV_CAP[lpsc_pkg::L1_ACC_MSB:lpsc_pkg::L1_ACC_LSB]
				<= ep_lat(IS_ENDPOINT, L1_ACC_LAT);
		end
	end

	// link capability word: support bits and exit latency codes;
	// read-only in the same way as the device word
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			LINK_CAP <= 32'h0000_0000;
		else
		begin
			LINK_CAP <= 32'h0000_0000;
			LINK_CAP[lpsc_pkg::ASPM_SUP_MSB:lpsc_pkg::ASPM_SUP_LSB]
				<= support_code(L0S_SUPPORT, L1_SUPPORT);
			LINK_CAP[lpsc_pkg::L0S_EXIT_MSB:lpsc_pkg::L0S_EXIT_LSB] <= L0S_EXIT_LAT;
			LINK_CAP[lpsc_pkg::L1_EXIT_MSB:lpsc_pkg::L1_EXIT_LSB]   <= L1_EXIT_LAT;
		end
	end

	// advertised fts count; the input is meant to be static, a change
	// shows one edge later with no handshake toward the link
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			NFTS_ADV <= 8'h00;
		else
			NFTS_ADV <= NFTS_COUNT;
	end

	// power state readback, one cycle behind the field that drives
	// the sequencer
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			PSTATE <= lpsc_pkg::PSTATE_RST;
		else
			PSTATE <= pstate;
	end
endmodule // lpsc_top
`default_nettype wire

// File: lpsc_peer.sv
// remote port model: answers entry requests with an ack
`timescale 1ns/1ps
`default_nettype none
module lpsc_peer
(
	input  wire logic        clk,     // core clock
	input  wire logic        rst,     // async reset
	input  wire logic        enter,   // enter-l1 request seen
	input  wire logic [15:0] ack_dly, // answer delay, 0 = silent
	output logic             ack      // ack pulse
);
	logic [15:0] cnt;
	logic        armed;

	// one answer per handshake; repeats must not restart the delay, as on a real link
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt   <= 16'h0;
			armed <= 1'b0;
			ack   <= 1'b0;
		end
		else
		begin
			ack <= armed && cnt == 16'h1;
			if (enter && !armed && ack_dly != 16'h0)
				armed <= 1'b1;
			else if (cnt == 16'h1)
				armed <= 1'b0;
			cnt <= (enter && !armed) ? ack_dly : cnt - 16'(armed);
		end
	end
endmodule // lpsc_peer
`default_nettype wire

// File: lpsc_top_asserts.sv
// checker: port properties of the power-state block
`timescale 1ns/1ps
`default_nettype none
module lpsc_top_chk
(
	input wire logic        REF_CLK,         // clock
	input wire logic        RST,             // reset
	input wire logic        IS_ENDPOINT,     // upstream
	input wire logic        L0S_SUPPORT,     // l0s offered
	input wire logic        L1_SUPPORT,      // l1 offered
	input wire logic [2:0]  L0S_ACC_LAT,     // l0s code
	input wire logic [2:0]  L1_ACC_LAT,      // l1 code
	input wire logic        L0S_SW_EN,       // l0s on
	input wire logic        L1_SW_EN,        // l1 on
	input wire logic        PSTATE_WR,       // write
	input wire logic [1:0]  PSTATE_WDATA,    // data
	input wire logic        PM_ACK_RCVD,     // ack
	input wire logic        LTSSM_L1_EXITED, // wake
	input wire logic [1:0]  PSTATE,          // readback
	input wire logic [31:0] DEV_CAP,         // caps
	input wire logic        TLP_BLOCK,       // hold
	input wire logic        SEND_ENTER_L1,   // request
	input wire logic        LTSSM_TO_L1,     // to l1
	input wire logic        LTSSM_TO_L0,     // to l0
	input wire logic        LTSSM_RECOVERY,  // recovery
	input wire logic        TX_L0S,          // in l0s
	input wire logic        LINK_IN_L1       // in l1
);
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	// handshake steps: request answered within one repeat gap, and a one-cycle wake
	sequence ask_s;
		SEND_ENTER_L1 ##[1:7] PM_ACK_RCVD;
	endsequence
	sequence wake_s;
		LTSSM_TO_L0 ##1 !LTSSM_TO_L0;
	endsequence

	dev_caps_a:
	assert property (1 |=> DEV_CAP[11:6] == ($past(IS_ENDPOINT) ?
		{$past(L1_ACC_LAT), $past(L0S_ACC_LAT)} : 6'h0)) else $error("latency fields wrong");
	pstate_back_a:
	assert property (PSTATE_WR |-> ##2 PSTATE == $past(PSTATE_WDATA, 2)) else $error("readback");
	block_start_a:
	assert property (PSTATE_WR && PSTATE_WDATA != lpsc_pkg::PSTATE_D0 |-> ##[1:3] TLP_BLOCK)
		else $error("no block");
	send_blocked_a:
	assert property (SEND_ENTER_L1 |-> TLP_BLOCK) else $error("request while unblocked");
	resend_gap_a:
	assert property (SEND_ENTER_L1 && !PM_ACK_RCVD ##1 !PM_ACK_RCVD [*7] |=> SEND_ENTER_L1)
		else $error("request not repeated");
	ack_l1_a:
	assert property (ask_s |=> LINK_IN_L1 && LTSSM_TO_L1) else $error("ack ignored");
	wake_a:
	assert property (LINK_IN_L1 && LTSSM_L1_EXITED |=> wake_s) else $error("no wake pulse");
	recov_pulse_a:
	assert property (LTSSM_RECOVERY |=> !LTSSM_RECOVERY) else $error("recovery held");
	l0s_gate_a:
	assert property ($rose(TX_L0S) |-> $past(L0S_SUPPORT && L0S_SW_EN, 2)) else $error("l0s");
	auto_gate_a:
	assert property (PSTATE == lpsc_pkg::PSTATE_D0 && !(IS_ENDPOINT && L1_SUPPORT && L1_SW_EN)
		|-> !SEND_ENTER_L1) else $error("autonomous l1 not allowed");
endmodule // lpsc_top_chk

bind lpsc_top lpsc_top_chk u_chk
(
	.REF_CLK, .RST, .IS_ENDPOINT, .L0S_SUPPORT, .L1_SUPPORT, .L0S_ACC_LAT, .L1_ACC_LAT,
	.L0S_SW_EN, .L1_SW_EN, .PSTATE_WR, .PSTATE_WDATA, .PM_ACK_RCVD, .LTSSM_L1_EXITED,
	.PSTATE, .DEV_CAP, .TLP_BLOCK, .SEND_ENTER_L1, .LTSSM_TO_L1, .LTSSM_TO_L0,
	.LTSSM_RECOVERY, .TX_L0S, .LINK_IN_L1
);
`default_nettype wire

// File: lpsc_top_tb_top.sv
// testbench: power-state block against the remote port model
`timescale 1ns/1ps
`default_nettype none
module lpsc_top_tb_top;
	logic        REF_CLK, RST, IS_ENDPOINT, L0S_SUPPORT, L1_SUPPORT, PSTATE_WR, L0S_SW_EN;
	logic        L1_SW_EN, TLP_PENDING, TLP_IN_PROGRESS, DLLP_ACTIVE, ACKNAK_ACTIVE;
	logic        REPLAY_EMPTY, PM_ACK_RCVD, LTSSM_L0S_EXITED, LTSSM_L1_EXITED, TLP_BLOCK;
	logic        SEND_ENTER_L1, LTSSM_TO_L1, LTSSM_TO_L0, LTSSM_RECOVERY, TX_L0S, LINK_IN_L1;
	logic [2:0]  L0S_ACC_LAT, L1_ACC_LAT, L0S_EXIT_LAT, L1_EXIT_LAT;
	logic [7:0]  NFTS_COUNT, NFTS_ADV;
	logic [15:0] L0S_IDLE_ENTRY_TIME, FTS_TIMEOUT_EXTENSION, L0S_EXIT_TIME, L1_IDLE_TIME, ack_dly;
	logic [1:0]  PSTATE_WDATA, PSTATE;
	logic [31:0] DEV_CAP, LINK_CAP;
	int          failures, n_compared, n, k, e, t;

	lpsc_top u_dut
	(
		.REF_CLK, .RST, .IS_ENDPOINT, .L0S_SUPPORT, .L1_SUPPORT, .L0S_ACC_LAT, .L1_ACC_LAT,
		.L0S_EXIT_LAT, .L1_EXIT_LAT, .NFTS_COUNT, .L0S_IDLE_ENTRY_TIME, .FTS_TIMEOUT_EXTENSION,
		.L0S_EXIT_TIME, .L1_IDLE_TIME, .PSTATE_WR, .PSTATE_WDATA, .L0S_SW_EN, .L1_SW_EN,
		.TLP_PENDING, .TLP_IN_PROGRESS, .DLLP_ACTIVE, .ACKNAK_ACTIVE, .REPLAY_EMPTY,
		.PM_ACK_RCVD, .LTSSM_L0S_EXITED, .LTSSM_L1_EXITED, .PSTATE, .DEV_CAP, .LINK_CAP,
		.NFTS_ADV, .TLP_BLOCK, .SEND_ENTER_L1, .LTSSM_TO_L1, .LTSSM_TO_L0, .LTSSM_RECOVERY,
		.TX_L0S, .LINK_IN_L1
	);
	lpsc_peer u_peer (.clk(REF_CLK), .rst(RST), .enter(SEND_ENTER_L1), .ack_dly, .ack(PM_ACK_RCVD));

	// expected capability words, built from field positions
	function automatic logic [31:0] dev_m(int ep, int a0, int a1);
		return ep ? 32'((a0 << 6) | (a1 << 9)) : 32'h0;
	endfunction
	function automatic logic [31:0] link_m(int s0, int s1, int x0, int x1);
		return 32'((s0 << 10) | (s1 << 11) | (x0 << 12) | (x1 << 15));
	endfunction

	// inputs move 2 ns after the edge so sampling never races them
	task automatic tick();
		@(posedge REF_CLK);
		#2;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bounded wait for a level; n holds the edges spent
	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim)
		begin
			tick();
			n++;
		end
	endtask
	// n counts the edges at which s showed high
	task automatic quiet(ref logic s, input int c);
		n = 0;
		repeat (c)
		begin
			tick();
			n += int'(s === 1'b1);
		end
	endtask
	task automatic wr(logic [1:0] v);
		PSTATE_WR = 1'b1;
		PSTATE_WDATA = v;
		tick();
		PSTATE_WR = 1'b0;
	endtask
	task automatic summarize();
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end

	// run is well under a thousand cycles; this is a generous ceiling
	initial
	begin
		#100000;
		failures++;
		summarize();
	end

	initial
	begin
		{IS_ENDPOINT, L0S_SUPPORT, L1_SUPPORT, PSTATE_WR, L0S_SW_EN, L1_SW_EN} = 6'h0;
		{TLP_PENDING, TLP_IN_PROGRESS, DLLP_ACTIVE, ACKNAK_ACTIVE, LTSSM_L0S_EXITED} = 5'h0;
		{LTSSM_L1_EXITED, PSTATE_WDATA, RST, REPLAY_EMPTY} = 5'h3;
		{L0S_ACC_LAT, L1_ACC_LAT, L0S_EXIT_LAT, L1_EXIT_LAT, NFTS_COUNT} = 20'h0;
		{L0S_IDLE_ENTRY_TIME, FTS_TIMEOUT_EXTENSION, L0S_EXIT_TIME, L1_IDLE_TIME} = 64'h0;
		ack_dly = 16'h3;
		failures = 0;
		n_compared = 0;
		void'($urandom(32'h4c24ed00));
		repeat (2) @(posedge REF_CLK);
		#2;
		RST = 1'b0;
		// capability words over every endpoint and support setting
		for (k = 0; k < 8; k++)
		begin
			{IS_ENDPOINT, L1_SUPPORT, L0S_SUPPORT} = 3'(k);
			{L0S_ACC_LAT, L1_ACC_LAT, L0S_EXIT_LAT, L1_EXIT_LAT, NFTS_COUNT} = 20'($urandom);
			tick();
			tick();
			chk(DEV_CAP, dev_m(IS_ENDPOINT, L0S_ACC_LAT, L1_ACC_LAT));
			chk(LINK_CAP, link_m(L0S_SUPPORT, L1_SUPPORT, L0S_EXIT_LAT, L1_EXIT_LAT));
			chk(32'(NFTS_ADV), 32'(NFTS_COUNT));
		end
		// software l1 for each non-d0 code; the wake cause alternates
		for (k = 1; k < 4; k++)
		begin
			{TLP_IN_PROGRESS, REPLAY_EMPTY} = 2'h2;
			ack_dly = 16'($urandom_range(20, 1));
			wr(2'(k));
			tick();
			chk(32'(PSTATE), 32'(k));
			wait_hi(TLP_BLOCK, 3);
			chk(32'(TLP_BLOCK), 32'h1);
			quiet(SEND_ENTER_L1, 5);
			TLP_IN_PROGRESS = 1'b0;
			chk(n, 0);
			quiet(SEND_ENTER_L1, 5);
			REPLAY_EMPTY = 1'b1;
			chk(n, 0);
			wait_hi(LINK_IN_L1, 40);
			chk(32'(LTSSM_TO_L1), 32'h1);
			wr(2'h0);
			{TLP_PENDING, LTSSM_L1_EXITED} = (k == 2) ? 2'h2 : 2'h1;
			wait_hi(LTSSM_TO_L0, 4);
			chk(32'(LTSSM_TO_L0), 32'h1);
			{TLP_PENDING, LTSSM_L1_EXITED} = 2'h0;
			quiet(LINK_IN_L1, 3);
			chk(n, 0);
			chk(32'({TLP_BLOCK, LTSSM_TO_L1}), 32'h0);
		end
		// l0s entry after the idle time, then an exit the ltssm never finishes
		e = $urandom_range(19, 4);
		t = $urandom_range(12, 3) + 10;
		{L0S_IDLE_ENTRY_TIME, L0S_EXIT_TIME, FTS_TIMEOUT_EXTENSION} = {16'(e), 16'ha, 16'(t - 10)};
		{L0S_SW_EN, DLLP_ACTIVE} = 2'h3;
		tick();
		DLLP_ACTIVE = 1'b0;
		wait_hi(TX_L0S, 30);
		chk(32'(n >= e && n <= e + 3), 32'h1);
		TLP_PENDING = 1'b1;
		wait_hi(LTSSM_RECOVERY, 60);
		chk(32'(n >= t && n <= t + 4), 32'h1);
		TLP_PENDING = 1'b0;
		wait_hi(TX_L0S, 30);
		chk(32'(TX_L0S), 32'h1);
		TLP_PENDING = 1'b1;
		tick();
		LTSSM_L0S_EXITED = 1'b1;
		quiet(LTSSM_RECOVERY, t + 6);
		chk(n, 0);
		{L0S_SW_EN, TLP_PENDING, LTSSM_L0S_EXITED} = 3'h0;
		quiet(TX_L0S, 30);
		chk(n, 0);
		// autonomous l1 as endpoint, then refused as a downstream port
		{L1_IDLE_TIME, ack_dly, L1_SW_EN, ACKNAK_ACTIVE} = {16'hc, 16'h3, 2'h3};
		tick();
		ACKNAK_ACTIVE = 1'b0;
		wait_hi(LINK_IN_L1, 60);
		chk(32'(n > 12 && n < 60), 32'h1);
		LTSSM_L1_EXITED = 1'b1;
		wait_hi(LTSSM_TO_L0, 4);
		chk(32'(LTSSM_TO_L0), 32'h1);
		{IS_ENDPOINT, LTSSM_L1_EXITED} = 2'h0;
		quiet(SEND_ENTER_L1, 40);
		chk(n, 0);
		summarize();
	end
endmodule // lpsc_top_tb_top
`default_nettype wire
